/* File: rtl/tsc_core.sv */
// Token stream core: three stage fetch/decode/execute pipeline.
// Assumes combinational instruction and shared data memory reads.
`timescale 1ns/1ps
module tsc_core
(
  input  wire logic                          clk,        // 40 MHz clock
  input  wire logic                          resetn,     // Sync, active low
  output logic [tsc_pkg::PC_W-1:0]           imem_addr,  // Fetch address
  input  wire logic [tsc_pkg::DATA_W-1:0]    imem_rdata, // Fetched word
  output tsc_pkg::tsc_dmem_req_t             dmem_req,   // Data mem request
  input  wire logic [tsc_pkg::DATA_W-1:0]    dmem_rdata, // Data mem read
  input  wire logic                          dma_valid,  // DMA word offered
  input  wire logic [tsc_pkg::FIFO_W-1:0]    dma_data,   // DMA word
  output logic                               dma_ready,  // FIFO has room
  input  wire logic                          tbl_we,     // Table write
  input  wire logic [tsc_pkg::TBL_AW-1:0]    tbl_waddr,  // Table address
  input  wire logic [tsc_pkg::DATA_W-1:0]    tbl_wdata,  // Table data
  output logic [tsc_pkg::DATA_W-1:0]         status_word // Flags word
);
  import tsc_pkg::*;

  typedef enum logic { TSC_EX_ISSUE, TSC_EX_FINISH } tsc_ex_state_t;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [PC_W-1:0]   pc_reg;
  logic [DATA_W-1:0] fetched_instruction_latch;
  logic              ir_valid_reg;
  tsc_dec_t          predecode_latch;
  tsc_dec_t          dec_in;
  logic              pd_valid_reg;
  logic [DATA_W-1:0] opa_reg;
  logic [DATA_W-1:0] opb_reg;
  logic [DATA_W-1:0] gpr_reg [NUM_GPR];
  logic [DATA_W-1:0] status_reg;
  tsc_ex_state_t     ex_state_reg;
  logic [2:0]        byte_idx_reg;
  tsc_dmem_req_t     dmem_req_reg;
  logic [2:0]        opb_idx;
  logic [DATA_W-1:0] opa_fwd;
  logic [DATA_W-1:0] opb_fwd;
  logic              ex_hold;
  logic              wb_en;
  logic [2:0]        wb_addr;
  logic [DATA_W-1:0] wb_data;
  logic              flag_we;
  logic [3:0]        flags_next;
  logic              jump_taken;
  logic [PC_W-1:0]   jump_target;
  logic              fifo_pop;
  logic              fifo_valid;
  logic [FIFO_W-1:0] fifo_data;
  logic [DATA_W-1:0] tbl_rdata;
  logic [DATA_W:0]   sum_ext;
  logic [DATA_W-1:0] res;
  logic [7:0]        fifo_byte;

  // ---------------------------------------------------------------
  // Bitstream FIFO and lookup table
  // ---------------------------------------------------------------
  // Compressed input buffer
  tsc_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (dma_valid),
    .in_data   (dma_data),
    .in_ready  (dma_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  tsc_mem #(.AW(TBL_AW), .W(DATA_W)) u_table
  (
    .clk     (clk),
    .wr_en   (tbl_we),
    .wr_addr (tbl_waddr),
    .wr_data (tbl_wdata),
    .rd_addr (opa_reg[TBL_AW-1:0]),
    .rd_data (tbl_rdata)
  );

  assign fifo_byte   = fifo_data[{byte_idx_reg, 3'h0} +: 8];
  assign imem_addr   = pc_reg;
  assign dmem_req    = dmem_req_reg;
  assign status_word = status_reg;

  // ---------------------------------------------------------------
  // Fetch stage
  // ---------------------------------------------------------------
  // First of the three stages
  // Target fetched, word after slot squashed
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pc_reg                    <= RESET_PC;
      fetched_instruction_latch <= 16'h0000;
      ir_valid_reg              <= 1'b0;
    end
    else if (!ex_hold)
    begin
      fetched_instruction_latch <= imem_rdata;
      if (jump_taken)
      begin
        pc_reg       <= jump_target;
        ir_valid_reg <= 1'b0;
      end
      else
      begin
        pc_reg       <= pc_reg + 1'b1;
        ir_valid_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Decode stage
  // ---------------------------------------------------------------
  // Field split of the held instruction
  assign dec_in.op     = fetched_instruction_latch[OP_POS +: 4];
  assign dec_in.rd     = fetched_instruction_latch[RD_POS +: 3];
  assign dec_in.ra     = fetched_instruction_latch[RA_POS +: 3];
  assign dec_in.rb     = fetched_instruction_latch[RB_POS +: 3];
  assign dec_in.sub    = fetched_instruction_latch[2:0];
  assign dec_in.imm    = fetched_instruction_latch[7:0];
  assign dec_in.hi     = fetched_instruction_latch[8];
  assign dec_in.target = fetched_instruction_latch[11:0];

  // Immediate byte loads and word stores read the destination register as operand b
  assign opb_idx = (dec_in.op == OP_LDI || dec_in.op == OP_STOREH) ?
                   dec_in.rd : dec_in.rb;

  // Same-cycle write-back bypass makes interlocks unnecessary
  assign opa_fwd = (wb_en && wb_addr == dec_in.ra) ? wb_data
                                                   : gpr_reg[dec_in.ra];
  assign opb_fwd = (wb_en && wb_addr == opb_idx) ? wb_data
                                                 : gpr_reg[opb_idx];

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      predecode_latch <= '0;
      pd_valid_reg    <= 1'b0;
      opa_reg         <= 16'h0000;
      opb_reg         <= 16'h0000;
    end
    else if (!ex_hold)
    begin
      predecode_latch <= dec_in;
      pd_valid_reg    <= ir_valid_reg;
      opa_reg         <= opa_fwd;
      opb_reg         <= opb_fwd;
    end
  end

  // ---------------------------------------------------------------
  // Execute stage
  // ---------------------------------------------------------------
  // Operation classes of the 16-bit datapath
  // Flags from ALU and compare ops
  always_comb
  begin
    ex_hold     = 1'b0;
    wb_en       = 1'b0;
    wb_addr     = predecode_latch.rd;
    wb_data     = 16'h0000;
    flag_we     = 1'b0;
    flags_next  = status_reg[FLAG_N_POS -: 4];
    jump_taken  = 1'b0;
    jump_target = predecode_latch.target[PC_W-1:0];
    fifo_pop    = 1'b0;
    sum_ext     = 17'h0;
    res         = 16'h0000;
    if (pd_valid_reg)
    begin
      case (predecode_latch.op)
        OP_ADD, OP_ADDC:
        begin
          sum_ext = {1'b0, opa_reg} + {1'b0, opb_reg} +
                    17'((predecode_latch.op == OP_ADDC) &&
                        status_reg[FLAG_N_POS - 2]);
          res     = sum_ext[DATA_W-1:0];
          flags_next = {res[15], res == 16'h0000, sum_ext[DATA_W],
                        (opa_reg[15] == opb_reg[15]) &&
                        (res[15] != opa_reg[15])};
          flag_we = 1'b1;
          wb_en   = 1'b1;
        end
        OP_SUB, OP_CMP:
        begin
          sum_ext = {1'b0, opa_reg} - {1'b0, opb_reg};
          res     = sum_ext[DATA_W-1:0];
          flags_next = {res[15], res == 16'h0000, sum_ext[DATA_W],
                        (opa_reg[15] != opb_reg[15]) &&
                        (res[15] != opa_reg[15])};
          flag_we = 1'b1;
          wb_en   = (predecode_latch.op == OP_SUB);
        end
        OP_AND, OP_OR:
        begin
          res = (predecode_latch.op == OP_AND) ? (opa_reg & opb_reg)
                                               : (opa_reg | opb_reg);
          flags_next = {res[15], res == 16'h0000, 2'b00};
          flag_we    = 1'b1;
          wb_en      = 1'b1;
        end
        OP_LDI:
        begin
          res   = predecode_latch.hi ? {predecode_latch.imm, opb_reg[7:0]}
                                     : {opb_reg[15:8], predecode_latch.imm};
          wb_en = 1'b1;
        end
        OP_LSHIFT:
        begin
          res   = opa_reg << ({1'b0, predecode_latch.sub} + 4'h1);
          wb_en = 1'b1;
        end
        // Load stays two cycles in execute
        OP_LOADH, OP_LOOKUP:
        begin
          ex_hold = (ex_state_reg == TSC_EX_ISSUE);
          wb_en   = (ex_state_reg == TSC_EX_FINISH);
          res     = (predecode_latch.op == OP_LOADH) ? dmem_rdata
                                                     : tbl_rdata;
        end
        // Byte fetch waits for FIFO data
        OP_GETB:
        begin
          ex_hold  = !fifo_valid;
          wb_en    = fifo_valid;
          res      = {8'h00, fifo_byte};
          fifo_pop = fifo_valid && (byte_idx_reg == LAST_BYTE);
        end
        OP_JMP:
          jump_taken = 1'b1;
        // Branch tests one flag against a polarity
        OP_BR:
        begin
          jump_taken  = status_reg[FLAG_N_POS - predecode_latch.sub[2:1]] ==
                        predecode_latch.sub[0];
          jump_target = opa_reg[PC_W-1:0];
        end
        default:
          res = 16'h0000;
      endcase
    end
    wb_data = res;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      ex_state_reg <= TSC_EX_ISSUE;
    else if (ex_state_reg == TSC_EX_FINISH)
      ex_state_reg <= TSC_EX_ISSUE;
    else if (pd_valid_reg && (predecode_latch.op == OP_LOADH ||
                              predecode_latch.op == OP_LOOKUP))
      ex_state_reg <= TSC_EX_FINISH;
  end

  // Shared memory request, one of three memories
  always_ff @(posedge clk)
  begin
    if (!resetn)
      dmem_req_reg <= '0;
    else
    begin
      dmem_req_reg.re    <= pd_valid_reg && ex_state_reg == TSC_EX_ISSUE &&
                            predecode_latch.op == OP_LOADH;
      dmem_req_reg.we    <= pd_valid_reg && predecode_latch.op == OP_STOREH;
      dmem_req_reg.sel   <= predecode_latch.sub[SEL_W-1:0];
      dmem_req_reg.addr  <= opa_reg;
      dmem_req_reg.wdata <= opb_reg;
    end
  end

  // Byte position inside the FIFO head word
  always_ff @(posedge clk)
  begin
    if (!resetn)
      byte_idx_reg <= 3'h0;
    else if (pd_valid_reg && predecode_latch.op == OP_GETB && fifo_valid)
      byte_idx_reg <= byte_idx_reg + 3'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NUM_GPR; i++)
        gpr_reg[i] <= 16'h0000;
    end
    else if (wb_en)
      gpr_reg[wb_addr] <= wb_data;
  end

  // Flags in the top four status bits
  always_ff @(posedge clk)
  begin
    if (!resetn)
      status_reg <= STATUS_RESET;
    else if (flag_we)
      status_reg[FLAG_N_POS:FLAG_LO] <= flags_next;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_reset_empties_pipe: assert property (disable iff (1'b0)
    !resetn |=> pc_reg == RESET_PC && !ir_valid_reg && !pd_valid_reg &&
               ex_state_reg == TSC_EX_ISSUE)
    else $error("pipeline not empty after reset");

  a_fetch_sequential: assert property (
    !ex_hold && !jump_taken |=>
      pc_reg == $past(pc_reg) + 1'b1 &&
      fetched_instruction_latch == $past(imem_rdata))
    else $error("fetch did not advance");

  a_decode_latches_ir: assert property (
    !ex_hold |=> pd_valid_reg == $past(ir_valid_reg) &&
                 predecode_latch == $past(dec_in))
    else $error("decode latch wrong");

  a_writeback_done: assert property (
    wb_en |=> gpr_reg[$past(wb_addr)] == $past(wb_data))
    else $error("write-back lost");

  a_flags_update: assert property (
    flag_we |=> status_reg[FLAG_N_POS:FLAG_LO] == $past(flags_next))
    else $error("flags not updated");

  a_multi_two_cycles: assert property (
    pd_valid_reg && predecode_latch.op == OP_LOADH &&
    ex_state_reg == TSC_EX_ISSUE |=>
      ex_state_reg == TSC_EX_FINISH ##1 ex_state_reg == TSC_EX_ISSUE)
    else $error("multi-cycle length wrong");

  a_hold_freezes: assert property (
    ex_hold |=> $stable(pc_reg) && $stable(predecode_latch) &&
                $stable(fetched_instruction_latch))
    else $error("stage moved during hold");

  a_jump_delay_slot: assert property (
    jump_taken && ir_valid_reg |=>
      pc_reg == $past(jump_target) && !ir_valid_reg && pd_valid_reg)
    else $error("delay slot wrong");

  a_fifo_pop_last: assert property (
    fifo_pop |-> predecode_latch.op == OP_GETB && byte_idx_reg == LAST_BYTE
                 ##1 byte_idx_reg == 3'h0)
    else $error("FIFO pop out of place");

  c_jump_taken: cover property (jump_taken ##1 pd_valid_reg);
  c_load_done:  cover property (dmem_req_reg.re ##0 wb_en);
  c_fifo_pop:   cover property (fifo_pop);
  c_long_hold:  cover property (ex_hold [*3]);
endmodule

/* File: rtl/tsc_fifo.sv */
// Bitstream FIFO with valid/ready on both sides.
// Assumes both sides run on the core clock.
`timescale 1ns/1ps
module tsc_fifo
#(
  parameter int W     = tsc_pkg::FIFO_W,
  parameter int DEPTH = tsc_pkg::FIFO_DEPTH
)
(
  input  wire logic         clk,       // Core clock
  input  wire logic         resetn,    // Sync reset, active low
  input  wire logic         in_valid,  // Write offered
  input  wire logic [W-1:0] in_data,   // Write word
  output logic              in_ready,  // Room for a word
  output logic              out_valid, // Word available
  output logic [W-1:0]      out_data,  // Head word
  input  wire logic         out_ready  // Head consumed
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          push;
  logic          pop;

  // Handshakes and occupancy
  assign push       = in_valid && in_ready;
  assign pop        = out_ready && out_valid;
  assign out_valid  = (count_reg != '0);
  assign out_data   = mem_reg[rd_ptr_reg];
  assign count_next = count_reg + CW'(push) - CW'(pop);

  // Storage
  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  // Pointers, count and registered ready
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      in_ready  <= (count_next < CW'(DEPTH));
    end
  end
endmodule

/* File: rtl/tsc_mem.sv */
// Lookup table memory, written by software, read by the core.
// Read data comes out of a register one clock after the address.
`timescale 1ns/1ps
module tsc_mem
#(
  parameter int AW = tsc_pkg::TBL_AW,
  parameter int W  = tsc_pkg::DATA_W
)
(
  input  wire logic          clk,     // Core clock
  input  wire logic          wr_en,   // Table write strobe
  input  wire logic [AW-1:0] wr_addr, // Table write address
  input  wire logic [W-1:0]  wr_data, // Table write data
  input  wire logic [AW-1:0] rd_addr, // Lookup address
  output logic      [W-1:0]  rd_data  // Registered lookup data
);
  logic [W-1:0] mem_reg [2**AW];

  // Write port and registered read port
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem_reg[wr_addr] <= wr_data;
    rd_data <= mem_reg[rd_addr];
  end
endmodule

/* File: rtl/tsc_pkg.sv */
// Shared constants and carrier types for the token stream core.
// Assumes one core clock and a synchronous active-low reset.
package tsc_pkg;

  // ---------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------
  localparam int DATA_W     = 16;
  localparam int NUM_GPR    = 8;
  localparam int PC_W       = 10;
  localparam int FIFO_W     = 64;  // Eight bytes per word
  localparam int FIFO_DEPTH = 8;   // 8 words = 64 bytes
  localparam int TBL_AW     = 8;
  localparam int SEL_W      = 2;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0]   RESET_PC     = 10'h000;
  localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;
  localparam int FLAG_N_POS = 15;
  localparam int FLAG_LO    = 12;  // Flags sit in bits 15..12
  localparam int OP_POS     = 12;
  localparam int RD_POS     = 9;
  localparam int RA_POS     = 6;
  localparam int RB_POS     = 3;
  localparam logic [2:0] LAST_BYTE = 3'h7;

  // ---------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_NOP    = 4'h0;
  localparam logic [3:0] OP_ADD    = 4'h1;
  localparam logic [3:0] OP_ADDC   = 4'h2;
  localparam logic [3:0] OP_SUB    = 4'h3;
  localparam logic [3:0] OP_CMP    = 4'h4;
  localparam logic [3:0] OP_AND    = 4'h5;
  localparam logic [3:0] OP_OR     = 4'h6;
  localparam logic [3:0] OP_LDI    = 4'h7;
  localparam logic [3:0] OP_LOADH  = 4'h8;
  localparam logic [3:0] OP_STOREH = 4'h9;
  localparam logic [3:0] OP_JMP    = 4'ha;
  localparam logic [3:0] OP_BR     = 4'hb;
  localparam logic [3:0] OP_GETB   = 4'hc;
  localparam logic [3:0] OP_LOOKUP = 4'hd;
  localparam logic [3:0] OP_LSHIFT = 4'he;

  // Predecoded instruction fields
  typedef struct packed {
    logic [3:0]  op;
    logic [2:0]  rd;
    logic [2:0]  ra;
    logic [2:0]  rb;
    logic [2:0]  sub;
    logic [7:0]  imm;
    logic        hi;
    logic [11:0] target;
  } tsc_dec_t;

  // Shared data memory request
  typedef struct packed {
    logic              re;
    logic              we;
    logic [SEL_W-1:0]  sel;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tsc_dmem_req_t;

endpackage

/* File: tb/testbench.sv */
// Self-checking bench for the token stream core.
// Assumes combinational instruction and data memory models here.
`timescale 1ns/1ps
module testbench;
  import tsc_pkg::*;
  typedef struct {
    logic [3:0]  op;
    logic [2:0]  sub;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] val;
    logic [3:0]  fl;
    logic        fchk;
  } tsc_row_t;
  logic                clk;
  logic                resetn;
  logic [PC_W-1:0]     imem_addr;
  logic [PC_W-1:0]     pc_seen;
  logic [DATA_W-1:0]   imem_rdata;
  logic [DATA_W-1:0]   dmem_rdata;
  logic [DATA_W-1:0]   status_word;
  logic [DATA_W-1:0]   tbl_wdata;
  logic [TBL_AW-1:0]   tbl_waddr;
  logic [FIFO_W-1:0]   dma_data;
  logic [7:0]          gap;
  logic                dma_valid;
  logic                dma_ready;
  logic                tbl_we;
  logic                en;
  tsc_dmem_req_t       dmem_req;
  logic [DATA_W-1:0]   imem [0:1023];
  int                  pushed;
  int                  errors;
  int                  comparisons;
  tsc_row_t rows [8] = '{
    '{OP_ADD,    3'h0, 16'h7fff, 16'h0001, 16'h8000, 4'h9, 1'b1},
    '{OP_ADD,    3'h0, 16'hffff, 16'h0001, 16'h0000, 4'h6, 1'b1},
    '{OP_ADDC,   3'h0, 16'h0001, 16'h0002, 16'h0003, 4'h0, 1'b1},
    '{OP_SUB,    3'h0, 16'h0003, 16'h0005, 16'hfffe, 4'ha, 1'b1},
    '{OP_CMP,    3'h0, 16'h1234, 16'h1234, 16'h0000, 4'h4, 1'b1},
    '{OP_AND,    3'h0, 16'hf0f0, 16'h0ff0, 16'h00f0, 4'h0, 1'b1},
    '{OP_OR,     3'h0, 16'h8000, 16'h0001, 16'h8001, 4'h8, 1'b1},
    '{OP_LSHIFT, 3'h7, 16'h00ab, 16'h0000, 16'hab00, 4'h0, 1'b0}};
  // ------------------------------------------------------------
  // Memories, clock and instances
  // ------------------------------------------------------------
  assign imem_rdata = imem[imem_addr];
  assign dmem_rdata = (dmem_req.re && dmem_req.sel == 2'h2) ? 16'h5aa5
                                                           : 16'ha55a;
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  tsc_core i_tsc_core (.clk(clk), .resetn(resetn), .imem_addr(imem_addr),
    .imem_rdata(imem_rdata), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
    .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready),
    .tbl_we(tbl_we), .tbl_waddr(tbl_waddr), .tbl_wdata(tbl_wdata),
    .status_word(status_word));
  tsc_dma_model i_tsc_dma_model (.clk(clk), .resetn(resetn), .en(en),
    .gap(gap), .dma_ready(dma_ready), .dma_valid(dma_valid),
    .dma_data(dma_data), .pushed(pushed));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] enc(logic [3:0] op, int rd, int ra,
                                      int rb, int sub);
    return {op, rd[2:0], ra[2:0], rb[2:0], sub[2:0]};
  endfunction
  function automatic logic [15:0] ldi(int rd, logic hi, logic [7:0] v);
    return {OP_LDI, rd[2:0], hi, v};
  endfunction
  task check(string nm, logic [63:0] got, logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task clear;
    foreach (imem[i])
      imem[i] = 16'h0000;
  endtask
  // Reset six cycles, check the cleared outputs, then release
  task start;
    @(posedge clk);
    #1 resetn = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check("reset fetch", imem_addr, RESET_PC);
    check("reset flags", status_word, STATUS_RESET);
    check("reset request", dmem_req, 0);
    check("reset ready", dma_ready, 1'b0);
    resetn = 1'b1;
  endtask
  task wait_store(string nm, logic [1:0] sel, logic [15:0] val);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (dmem_req.we !== 1'b1 && n < 60);
    check("store strobe", dmem_req.we, 1'b1);
    check("store select", dmem_req.sel, sel);
    check(nm, dmem_req.wdata, val);
  endtask
  // ------------------------------------------------------------
  // Watchdog and main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (6000) @(posedge clk);
    errors++;
    finish_test;
  end
  initial
  begin
    resetn = 1'b0;
    tbl_we = 1'b0;
    tbl_waddr = 8'h00;
    tbl_wdata = 16'h0000;
    en = 1'b0;
    gap = 8'h00;
    errors = 0;
    comparisons = 0;
    foreach (rows[i])
    begin
      clear;
      imem[0] = ldi(1, 1'b0, rows[i].a[7:0]);
      imem[1] = ldi(1, 1'b1, rows[i].a[15:8]);
      imem[2] = ldi(2, 1'b0, rows[i].b[7:0]);
      imem[3] = ldi(2, 1'b1, rows[i].b[15:8]);
      imem[4] = enc(rows[i].op, 3, 1, 2, rows[i].sub);
      imem[5] = enc(OP_STOREH, 3, 1, 0, i % 3);
      start;
      wait_store("alu result", 2'(i % 3), rows[i].val);
      check("store address", dmem_req.addr, rows[i].a);
      if (rows[i].fchk)
        check("flags", status_word, {rows[i].fl, 12'h000});
    end
    clear;
    imem[0] = {OP_JMP, 2'b00, 10'h008};
    imem[1] = ldi(2, 1'b0, 8'h22);
    imem[2] = ldi(3, 1'b0, 8'h33);
    imem[8] = enc(OP_STOREH, 2, 0, 0, 0);
    imem[9] = enc(OP_STOREH, 3, 0, 0, 0);
    start;
    wait_store("delay slot", 2'h0, 16'h0022);
    wait_store("squashed word", 2'h0, 16'h0000);
    // Branch on Z: first one not taken, second one taken
    clear;
    imem[0] = ldi(1, 1'b0, 8'h10);
    imem[1] = enc(OP_CMP, 0, 1, 1, 0);
    imem[2] = enc(OP_BR, 0, 1, 0, 2);
    imem[3] = enc(OP_BR, 0, 1, 0, 3);
    imem[4] = ldi(2, 1'b0, 8'h44);
    imem[5] = ldi(3, 1'b0, 8'h55);
    imem[16] = enc(OP_STOREH, 2, 0, 0, 0);
    imem[17] = enc(OP_STOREH, 3, 0, 0, 0);
    start;
    wait_store("branch slot", 2'h0, 16'h0044);
    wait_store("branch squash", 2'h0, 16'h0000);
    clear;
    imem[0] = enc(OP_LOADH, 1, 0, 0, 2);
    imem[1] = enc(OP_STOREH, 1, 0, 0, 1);
    start;
    wait_store("loaded word", 2'h1, 16'h5aa5);
    @(posedge clk);
    #1 tbl_we = 1'b1;
    tbl_waddr = 8'h05;
    tbl_wdata = 16'hc3a5;
    @(posedge clk);
    #1 tbl_we = 1'b0;
    clear;
    imem[0] = ldi(1, 1'b0, 8'h05);
    imem[1] = enc(OP_LOOKUP, 2, 1, 0, 0);
    imem[2] = enc(OP_STOREH, 2, 0, 0, 0);
    start;
    wait_store("table word", 2'h0, 16'hc3a5);
    imem[0] = enc(OP_GETB, 1, 0, 0, 0);
    start;
    repeat (10) @(posedge clk);
    #1 pc_seen = imem_addr;
    repeat (5) @(posedge clk);
    #1 check("held fetch", imem_addr, pc_seen);
    foreach (rows[g])
      if (g < 2)
      begin
        clear;
        for (int k = 0; k < 9; k++)
        begin
          imem[40+2*k] = enc(OP_GETB, 1, 0, 0, 0);
          imem[41+2*k] = enc(OP_STOREH, 1, 0, 0, 0);
        end
        en = 1'b1;
        gap = 8'(g * 3);
        start;
        repeat (30) @(posedge clk);
        #1;
        if (g == 0)
        begin
          check("full refusal", dma_ready, 1'b0);
          check("words held", pushed, FIFO_DEPTH);
        end
        for (int k = 0; k < 9; k++)
          wait_store("stream byte", 2'h0, 16'(k));
      end
    finish_test;
  end
endmodule

/* File: tb/tsc_dma_model.sv */
// DMA stand-in filling the bitstream FIFO, prompt or with gaps.
// Assumes the core clock and the core's synchronous reset.
`timescale 1ns/1ps
module tsc_dma_model
(
  input  wire logic       clk,       // Core clock
  input  wire logic       resetn,    // Sync reset, active low
  input  wire logic       en,        // Offer words
  input  wire logic [7:0] gap,       // Idle cycles between words
  input  wire logic       dma_ready, // FIFO has room
  output logic            dma_valid, // Word offered
  output logic [63:0]     dma_data,  // Byte 8n+i in lane i
  output int              pushed     // Words taken
);
  logic [7:0]  idle;
  logic [63:0] w;
  logic        take;
  logic        rst;
  // ------------------------------------------------------------
  // Offer loop, changes just after each edge
  // ------------------------------------------------------------
  initial
  begin
    dma_valid = 1'b0;
    dma_data  = 64'h0;
    pushed    = 0;
    idle      = 8'h00;
    forever
    begin
      @(posedge clk);
      take = dma_valid && dma_ready;
      rst  = !resetn;
      #1;
      if (rst)
      begin
        dma_valid = 1'b0;
        pushed    = 0;
        idle      = 8'h00;
      end
      else if (take || !dma_valid)
      begin
        if (take)
        begin
          pushed++;
          idle = gap;
        end
        for (int i = 0; i < 8; i++)
          w[i*8+:8] = 8'(pushed * 8 + i);
        if (en && idle == 8'h00)
        begin
          dma_valid = 1'b1;
          dma_data  = w;
        end
        else
        begin
          dma_valid = 1'b0;
          dma_data  = ~dma_data; // Released lane toggles
          if (idle != 8'h00)
            idle--;
        end
      end
    end
  end
endmodule
